// ==== idp_identify.sv ====
// Purpose: Identify parameter block of a storage card, read word by word over AXI4-Lite.
// Assumes: Single clock, synchronous active-low reset, one AXI4-Lite master.
// Notes: Words are generated on the fly, no sector buffer memory is needed.
`timescale 1ns/1ps
module idp_identify #(
    parameter logic [31:0] CAPACITY = 32'h0003_D800,
    parameter logic [15:0] CYLINDERS = 16'h00F4,
    parameter logic [159:0] SERIAL_STR = "SN000000000000000001",
    parameter logic [63:0] FW_STR = "REV 1.00",
    parameter logic [319:0] MODEL_STR = "GENERIC STORAGE CARD                    "
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [idp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [idp_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [idp_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [idp_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output idp_pkg::idp_status_t status,
    output logic intrq
);

    // ----------------------------------------------------------------
    // Reset image
    // ----------------------------------------------------------------
    localparam idp_pkg::idp_regs_t RST = '{
        st: idp_pkg::IDP_IDLE,
        idx: '0,
        irq: 1'b0,
        cap: CAPACITY,
        cyl: CYLINDERS,
        multi: idp_pkg::MULTI_RST,
        pcm: 1'b0,
        usel: '0,
        usel_en: 1'b0,
        aw_got: 1'b0,
        awaddr: '0,
        w_got: 1'b0,
        wdata: '0,
        wstrb: '0,
        bvalid: 1'b0,
        bresp: idp_pkg::RESP_OKAY,
        rvalid: 1'b0,
        rdata: '0,
        rresp: idp_pkg::RESP_OKAY
    };

    idp_pkg::idp_regs_t r_r;
    idp_pkg::idp_regs_t r_nxt;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Byte-lane merge of a write into an existing register value
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Text word k of an n-character string; the first character sits in the high byte
    function automatic logic [15:0] str_word(
        input logic [319:0] s,
        input int n,
        input int k
    );
        logic [319:0] sh;
        sh = s >> (8 * n - 16 * (k + 1));
        return sh[15:0];
    endfunction

    // Content of one identify word, built from constants and live settings
    function automatic logic [15:0] ident_word(
        input logic [7:0] idx,
        input idp_pkg::idp_regs_t s
    );
        logic [15:0] w;
        int i;
        w = '0;
        i = int'(idx);
        case (i) inside
            idp_pkg::W_GENCFG: w = idp_pkg::V_GENCFG;
            idp_pkg::W_CYL, idp_pkg::W_CUR_CYL: w = s.cyl;
            idp_pkg::W_HEADS, idp_pkg::W_CUR_HEADS: w = idp_pkg::V_HEADS;
            idp_pkg::W_SPT, idp_pkg::W_CUR_SPT: w = idp_pkg::V_SPT;
            idp_pkg::W_CARD_HI: w = s.cap[31:16];
            idp_pkg::W_CARD_LO: w = s.cap[15:0];
            [idp_pkg::W_SER_F:idp_pkg::W_SER_L]: begin
                w = str_word({160'h0, SERIAL_STR}, idp_pkg::SER_CHARS,
                    i - idp_pkg::W_SER_F);
            end
            idp_pkg::W_RET_A, idp_pkg::W_RET_B: w = idp_pkg::V_RET;
            idp_pkg::W_OBS22: w = idp_pkg::V_OBS22;
            [idp_pkg::W_FW_F:idp_pkg::W_FW_L]: begin
                w = str_word({256'h0, FW_STR}, idp_pkg::FW_CHARS,
                    i - idp_pkg::W_FW_F);
            end
            [idp_pkg::W_MOD_F:idp_pkg::W_MOD_L]: begin
                w = str_word(MODEL_STR, idp_pkg::MOD_CHARS,
                    i - idp_pkg::W_MOD_F);
            end
            idp_pkg::W_MULTMAX: w = idp_pkg::V_MULTMAX;
            idp_pkg::W_CAPAB: w = idp_pkg::V_CAPAB;
            idp_pkg::W_PIO: w = idp_pkg::V_PIO;
            idp_pkg::W_VALID: w = idp_pkg::V_VALID;
            idp_pkg::W_CURCAP_LO, idp_pkg::W_TOT_LO: w = s.cap[15:0];
            idp_pkg::W_CURCAP_HI, idp_pkg::W_TOT_HI: w = s.cap[31:16];
            idp_pkg::W_MULTSET: w = {7'h00, s.multi};
            idp_pkg::W_MDMA: w = idp_pkg::V_MDMA;
            idp_pkg::W_APIO: w = idp_pkg::V_APIO;
            idp_pkg::W_MDMA_MIN, idp_pkg::W_MDMA_REC: begin
                w = s.pcm ? 16'h0000 : idp_pkg::V_CYCLE;
            end
            idp_pkg::W_PIO_MIN, idp_pkg::W_PIO_IORDY: w = idp_pkg::V_CYCLE;
            [idp_pkg::W_SER_IF_F:idp_pkg::W_SER_IF_L]: w = 16'h0000;
            idp_pkg::W_VER_MAJ: w = idp_pkg::V_VER_MAJ;
            idp_pkg::W_VER_MIN: w = idp_pkg::V_VER_MIN;
            idp_pkg::W_SUP1: w = idp_pkg::V_SUP1;
            idp_pkg::W_SUP2: w = idp_pkg::V_SUP2;
            idp_pkg::W_SUPX, idp_pkg::W_ENX: w = idp_pkg::V_EXT;
            idp_pkg::W_EN1: w = idp_pkg::V_EN1;
            idp_pkg::W_EN2: w = idp_pkg::V_EN2;
            idp_pkg::W_UDMA: begin
                // Only supported modes can be flagged as selected
                w[7:0] = idp_pkg::V_UDMA_SUP;
                if (s.usel_en && idp_pkg::V_UDMA_SUP[s.usel]) begin
                    w[8 + int'(s.usel)] = 1'b1;
                end
            end
            default: w = 16'h0000;
        endcase
        return w;
    endfunction

    // ----------------------------------------------------------------
    // Bus handshakes
    // ----------------------------------------------------------------
    // One write in flight; address and data may arrive in either order
    assign s_axi_awready = !r_r.aw_got && !r_r.bvalid;
    assign s_axi_wready = !r_r.w_got && !r_r.bvalid;
    assign s_axi_arready = !r_r.rvalid;
    assign s_axi_bvalid = r_r.bvalid;
    assign s_axi_bresp = r_r.bresp;
    assign s_axi_rvalid = r_r.rvalid;
    assign s_axi_rdata = r_r.rdata;
    assign s_axi_rresp = r_r.rresp;
    assign status.busy = (r_r.st == idp_pkg::IDP_BUSY);
    assign status.drq = (r_r.st == idp_pkg::IDP_DRQ);
    assign intrq = r_r.irq;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic irq_set;
        logic irq_clr;
        logic [31:0] wv;
        irq_set = 1'b0;
        irq_clr = 1'b0;
        wv = '0;
        r_nxt = r_r;

        // Command engine
        case (r_r.st)
            idp_pkg::IDP_IDLE: begin
                r_nxt.st = idp_pkg::IDP_IDLE;
            end
            idp_pkg::IDP_BUSY: begin
                // Words are generated live, so data is ready one cycle later
                r_nxt.st = idp_pkg::IDP_DRQ;
                irq_set = 1'b1;
            end
            idp_pkg::IDP_DRQ: begin
                r_nxt.st = idp_pkg::IDP_DRQ;
            end
            default: begin
                r_nxt.st = idp_pkg::IDP_IDLE;
            end
        endcase

        // Write channel capture
        if (s_axi_awvalid && s_axi_awready) begin
            r_nxt.aw_got = 1'b1;
            r_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            r_nxt.w_got = 1'b1;
            r_nxt.wdata = s_axi_wdata;
            r_nxt.wstrb = s_axi_wstrb;
        end
        if (r_r.bvalid && s_axi_bready) begin
            r_nxt.bvalid = 1'b0;
        end

        // Register write once both halves are in
        if (r_r.aw_got && r_r.w_got) begin
            r_nxt.aw_got = 1'b0;
            r_nxt.w_got = 1'b0;
            r_nxt.bvalid = 1'b1;
            r_nxt.bresp = idp_pkg::RESP_OKAY;
            case (r_r.awaddr)
                idp_pkg::OFF_CMD: begin
                    // A new command is only accepted while idle
                    if (r_r.wstrb[0] && r_r.wdata[7:0] == idp_pkg::CMD_IDENTIFY &&
                        r_r.st == idp_pkg::IDP_IDLE) begin
                        r_nxt.st = idp_pkg::IDP_BUSY;
                        r_nxt.idx = '0;
                    end
                end
                idp_pkg::OFF_CAP: begin
                    r_nxt.cap = merge(r_r.cap, r_r.wdata, r_r.wstrb);
                end
                idp_pkg::OFF_CYL: begin
                    wv = merge({16'h0, r_r.cyl}, r_r.wdata, r_r.wstrb);
                    r_nxt.cyl = wv[15:0];
                end
                idp_pkg::OFF_MULTI: begin
                    wv = merge({23'h0, r_r.multi}, r_r.wdata, r_r.wstrb);
                    r_nxt.multi = wv[8:0];
                end
                idp_pkg::OFF_MODE: begin
                    if (r_r.wstrb[0]) begin
                        r_nxt.pcm = r_r.wdata[idp_pkg::MODE_PCM];
                        r_nxt.usel = r_r.wdata[idp_pkg::MODE_USEL_LSB +: 3];
                        r_nxt.usel_en = r_r.wdata[idp_pkg::MODE_USEL_EN];
                    end
                end
                idp_pkg::OFF_STATUS, idp_pkg::OFF_DATA, idp_pkg::OFF_INDEX: begin
                    r_nxt.bresp = idp_pkg::RESP_OKAY;
                end
                default: begin
                    r_nxt.bresp = idp_pkg::RESP_DECERR;
                end
            endcase
        end

        // Read channel
        if (r_r.rvalid && s_axi_rready) begin
            r_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            r_nxt.rvalid = 1'b1;
            r_nxt.rresp = idp_pkg::RESP_OKAY;
            r_nxt.rdata = '0;
            case (s_axi_araddr)
                idp_pkg::OFF_STATUS: begin
                    r_nxt.rdata[idp_pkg::ST_BSY] = (r_r.st == idp_pkg::IDP_BUSY);
                    r_nxt.rdata[idp_pkg::ST_DRQ] = (r_r.st == idp_pkg::IDP_DRQ);
                    r_nxt.rdata[idp_pkg::ST_IRQ] = r_r.irq;
                    // Reading status acknowledges the interrupt
                    irq_clr = 1'b1;
                end
                idp_pkg::OFF_DATA: begin
                    // Outside a data phase the port reads zero with no side effect
                    if (r_r.st == idp_pkg::IDP_DRQ) begin
                        r_nxt.rdata = {16'h0000, ident_word(r_r.idx, r_r)};
                        r_nxt.idx = r_r.idx + 8'h01;
                        if (r_r.idx == idp_pkg::LAST_WORD) begin
                            // 256 words, 512 bytes, end the data phase
                            r_nxt.st = idp_pkg::IDP_IDLE;
                            r_nxt.idx = '0;
                        end
                    end
                end
                idp_pkg::OFF_CAP: r_nxt.rdata = r_r.cap;
                idp_pkg::OFF_CYL: r_nxt.rdata = {16'h0000, r_r.cyl};
                idp_pkg::OFF_MULTI: r_nxt.rdata = {23'h0, r_r.multi};
                idp_pkg::OFF_MODE: begin
                    r_nxt.rdata[idp_pkg::MODE_PCM] = r_r.pcm;
                    r_nxt.rdata[idp_pkg::MODE_USEL_LSB +: 3] = r_r.usel;
                    r_nxt.rdata[idp_pkg::MODE_USEL_EN] = r_r.usel_en;
                end
                idp_pkg::OFF_INDEX: r_nxt.rdata = {24'h0, r_r.idx};
                idp_pkg::OFF_CMD: r_nxt.rdata = '0;
                default: r_nxt.rresp = idp_pkg::RESP_DECERR;
            endcase
        end

        // A fresh ready event beats an acknowledge in the same cycle
        r_nxt.irq = irq_set | (r_r.irq & ~irq_clr);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_r <= RST;
        end else begin
            r_r <= r_nxt;
        end
    end

endmodule

// ==== idp_pkg.sv ====
// Purpose: Shared constants and types for the identify parameter block.
// Assumes: AXI4-Lite slave with 8-bit byte addresses and 32-bit data.
// Notes: Word values are fixed content of the 256-word identify block.
package idp_pkg;

    // ----------------------------------------------------------------
    // Bus and register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_DATA = 8'h08;
    localparam logic [7:0] OFF_CAP = 8'h0C;
    localparam logic [7:0] OFF_CYL = 8'h10;
    localparam logic [7:0] OFF_MULTI = 8'h14;
    localparam logic [7:0] OFF_MODE = 8'h18;
    localparam logic [7:0] OFF_INDEX = 8'h1C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam logic [7:0] CMD_IDENTIFY = 8'hEC;
    localparam int ST_BSY = 0;
    localparam int ST_DRQ = 1;
    localparam int ST_IRQ = 2;
    localparam int MODE_PCM = 0;
    localparam int MODE_USEL_LSB = 1;
    localparam int MODE_USEL_EN = 4;
    localparam logic [8:0] MULTI_RST = 9'h102;
    localparam logic [7:0] LAST_WORD = 8'hFF;

    // ----------------------------------------------------------------
    // Word indices of the parameter block
    // ----------------------------------------------------------------
    localparam int W_GENCFG = 0;
    localparam int W_CYL = 1;
    localparam int W_HEADS = 3;
    localparam int W_SPT = 6;
    localparam int W_CARD_HI = 7;
    localparam int W_CARD_LO = 8;
    localparam int W_SER_F = 10;
    localparam int W_SER_L = 19;
    localparam int W_RET_A = 20;
    localparam int W_RET_B = 21;
    localparam int W_OBS22 = 22;
    localparam int W_FW_F = 23;
    localparam int W_FW_L = 26;
    localparam int W_MOD_F = 27;
    localparam int W_MOD_L = 46;
    localparam int W_MULTMAX = 47;
    localparam int W_CAPAB = 49;
    localparam int W_PIO = 51;
    localparam int W_VALID = 53;
    localparam int W_CUR_CYL = 54;
    localparam int W_CUR_HEADS = 55;
    localparam int W_CUR_SPT = 56;
    localparam int W_CURCAP_LO = 57;
    localparam int W_CURCAP_HI = 58;
    localparam int W_MULTSET = 59;
    localparam int W_TOT_LO = 60;
    localparam int W_TOT_HI = 61;
    localparam int W_MDMA = 63;
    localparam int W_APIO = 64;
    localparam int W_MDMA_MIN = 65;
    localparam int W_MDMA_REC = 66;
    localparam int W_PIO_MIN = 67;
    localparam int W_PIO_IORDY = 68;
    localparam int W_SER_IF_F = 76;
    localparam int W_SER_IF_L = 79;
    localparam int W_VER_MAJ = 80;
    localparam int W_VER_MIN = 81;
    localparam int W_SUP1 = 82;
    localparam int W_SUP2 = 83;
    localparam int W_SUPX = 84;
    localparam int W_EN1 = 85;
    localparam int W_EN2 = 86;
    localparam int W_ENX = 87;
    localparam int W_UDMA = 88;
    localparam int SER_CHARS = 20;
    localparam int FW_CHARS = 8;
    localparam int MOD_CHARS = 40;

    // ----------------------------------------------------------------
    // Word values
    // ----------------------------------------------------------------
    localparam logic [15:0] V_GENCFG = 16'h045A;
    localparam logic [15:0] V_HEADS = 16'h0010;
    localparam logic [15:0] V_SPT = 16'h003F;
    localparam logic [15:0] V_RET = 16'h0002;
    localparam logic [15:0] V_OBS22 = 16'h0004;
    localparam logic [15:0] V_MULTMAX = 16'h8002;
    localparam logic [15:0] V_CAPAB = 16'h0F00;
    localparam logic [15:0] V_PIO = 16'h0200;
    localparam logic [15:0] V_VALID = 16'h0007;
    localparam logic [15:0] V_MDMA = 16'h0007;
    localparam logic [15:0] V_APIO = 16'h0003;
    localparam logic [15:0] V_CYCLE = 16'h0078;
    localparam logic [15:0] V_VER_MAJ = 16'h0020;
    localparam logic [15:0] V_VER_MIN = 16'h0000;
    localparam logic [15:0] V_SUP1 = 16'h700A;
    localparam logic [15:0] V_SUP2 = 16'h5004;
    localparam logic [15:0] V_EXT = 16'h4000;
    localparam logic [15:0] V_EN1 = 16'h7008;
    localparam logic [15:0] V_EN2 = 16'h1004;
    localparam logic [7:0] V_UDMA_SUP = 8'h1F;

    typedef enum logic [1:0] {
        IDP_IDLE = 2'h0,
        IDP_BUSY = 2'h1,
        IDP_DRQ = 2'h3
    } idp_state_t;

    typedef struct packed {
        logic busy;
        logic drq;
    } idp_status_t;

    typedef struct packed {
        idp_state_t st;
        logic [7:0] idx;
        logic irq;
        logic [31:0] cap;
        logic [15:0] cyl;
        logic [8:0] multi;
        logic pcm;
        logic [2:0] usel;
        logic usel_en;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } idp_regs_t;

endpackage

// ==== idp_identify_checker.sv ====
// Purpose: Port-level handshake and status checks for the identify block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every instance of the identify block.
`timescale 1ns/1ps
module idp_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [idp_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire idp_pkg::idp_status_t status,
    input wire logic intrq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before accepted");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before accepted");
    rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    wr_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    rd_cause_a: assert property (!s_axi_rvalid && !(s_axi_arvalid && s_axi_arready)
        |=> !s_axi_rvalid)
        else $error("read answer without a read request");
    wr_cause_a: assert property ($rose(s_axi_bvalid)
        |-> $past(s_axi_awvalid && s_axi_awready, 2) || $past(s_axi_wvalid && s_axi_wready, 2))
        else $error("write answer without a write request");
    busy_drq_a: assert property (status.busy |=> !status.busy && status.drq)
        else $error("busy not followed by data request");
    drq_irq_a: assert property ($rose(status.drq) |-> intrq)
        else $error("no interrupt with data request");
    drq_fall_a: assert property ($fell(status.drq)
        |-> $past(s_axi_arvalid && s_axi_arready) || $past(s_axi_rvalid && s_axi_rready))
        else $error("data request dropped without a read");
endmodule

bind idp_identify idp_checker idp_checker_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .status, .intrq);

// ==== idp_host_model.sv ====
// Purpose: Host side model reading the identify block over AXI4-Lite.
// Assumes: Tasks are entered just after a rising edge.
// Notes: Ready can lag to exercise slow hosts; released payloads are inverted.
`timescale 1ns/1ps
module idp_host_model (
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input int lag,
        output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
            if (s_axi_bvalid && s_axi_bready) break;
            if (n == lag) s_axi_bready <= 1'b1;
            n++;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // One 16-bit word per read of the data port
    task automatic rd(input logic [7:0] a, input int lag, output logic [31:0] d,
        output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
            if (s_axi_rvalid && s_axi_rready) break;
            if (n == lag) s_axi_rready <= 1'b1;
            n++;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

// ==== tb_idp_identify.sv ====
// Purpose: Self-checking bench for the identify parameter block.
// Assumes: 100 MHz clock, synchronous active-low reset.
// Notes: Current geometry words 55 and 56 repeat the default heads and sectors.
`timescale 1ns/1ps
module tb_idp_identify;
    localparam logic [31:0] CAP = 32'h0001_F400;
    localparam logic [15:0] CYL = 16'h0123;
    localparam logic [159:0] SER = "SERIAL-NUMBER-00042A";
    localparam logic [63:0] FW = "FW 2.31x";
    localparam logic [319:0] MDL = "TEST MODEL STRING FOR IDENTIFY BLOCK 40C";
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, intrq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    idp_pkg::idp_status_t status;
    int failures = 0;
    int cmp_count = 0;

    idp_identify #(.CAPACITY(CAP), .CYLINDERS(CYL), .SERIAL_STR(SER), .FW_STR(FW),
        .MODEL_STR(MDL)) idp_identify_inst (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .status, .intrq);
    idp_host_model host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // --------------------------------------------------------------
    // Checking helpers
    // --------------------------------------------------------------
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test;
        if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    function automatic logic [15:0] exp_word(int i, logic [4:0] md, logic [8:0] mu,
        logic [31:0] cp);
        logic [15:0] w;
        w = 16'h0000;
        if (i >= 10 && i <= 19) w = SER[159-16*(i-10) -: 16];
        if (i >= 23 && i <= 26) w = FW[63-16*(i-23) -: 16];
        if (i >= 27 && i <= 46) w = MDL[319-16*(i-27) -: 16];
        if (i >= 65 && i <= 68 && !(md[0] && i < 67)) w = 16'h0078;
        case (i)
            0: w = 16'h045A;
            1, 54: w = CYL;
            3, 55: w = 16'h0010;
            6, 56: w = 16'h003F;
            7, 58, 61: w = cp[31:16];
            8, 57, 60: w = cp[15:0];
            20, 21: w = 16'h0002;
            22: w = 16'h0004;
            47: w = 16'h8002;
            49: w = 16'h0F00;
            51: w = 16'h0200;
            53, 63: w = 16'h0007;
            59: w = {7'h00, mu};
            64: w = 16'h0003;
            80: w = 16'h0020;
            82: w = 16'h700A;
            83: w = 16'h5004;
            84, 87: w = 16'h4000;
            85: w = 16'h7008;
            86: w = 16'h1004;
            88: w = {(md[4] && md[3:1] <= 3'h4) ? 8'h01 << md[3:1] : 8'h00, 8'h1F};
            default: ;
        endcase
        return w;
    endfunction

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_bus;
        logic [31:0] d;
        logic [1:0] r;
        chk("status", 32'h0, 32'(status));
        host.rd(8'h20, 1, d, r);
        chk("rresp", 32'h3, 32'(r));
        chk("rdata", 32'h0, d);
        host.wr(8'h22, 32'h0000_00EC, 0, r);
        chk("bresp", 32'h3, 32'(r));
        host.rd(idp_pkg::OFF_DATA, 0, d, r);
        chk("idle_data", 32'h0, d);
    endtask

    task automatic t_identify(logic [4:0] md, logic [8:0] mu, logic [31:0] cp, bit again);
        logic [31:0] d;
        logic [1:0] r;
        int n;
        n = 0;
        host.wr(idp_pkg::OFF_MODE, {27'h0, md}, 0, r);
        if (mu !== 9'h102) host.wr(idp_pkg::OFF_MULTI, {23'h0, mu}, 1, r);
        if (cp !== CAP) host.wr(idp_pkg::OFF_CAP, cp, 0, r);
        host.wr(idp_pkg::OFF_CMD, 32'h0000_00EC, 2, r);
        chk("cmd_resp", 32'h0, 32'(r));
        while (intrq !== 1'b1 && n < 20) begin
            @(posedge aclk);
            n++;
        end
        chk("intrq_set", 32'h1, 32'(intrq));
        host.rd(idp_pkg::OFF_STATUS, 0, d, r);
        chk("status_reg", 32'h6, d);
        chk("intrq_clear", 32'h0, 32'(intrq));
        for (int i = 0; i < 256; i++) begin
            if (again && i == 100) begin
                host.wr(idp_pkg::OFF_CMD, 32'h0000_00EC, 0, r);
                chk("busy_cmd", 32'h0, 32'(r));
            end
            host.rd(idp_pkg::OFF_DATA, i % 4, d, r);
            chk($sformatf("word%0d", i), {16'h0, exp_word(i, md, mu, cp)}, d);
        end
        chk("drq_end", 32'h0, 32'(status.drq));
    endtask

    task automatic t_midreset;
        logic [1:0] r;
        host.wr(idp_pkg::OFF_CMD, 32'h0000_00EC, 0, r);
        repeat (3) @(posedge aclk);
        chk("drq_set", 32'h1, 32'(status.drq));
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("rst_status", 32'h0, {29'h0, intrq, status});
    endtask

    initial begin
        aresetn = 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_bus();
        t_identify(5'h14, 9'h102, CAP, 1'b0);
        t_midreset();
        t_identify(5'h1B, 9'h104, 32'h1234_5678, 1'b1);
        stop_test();
    end

    // Whole run needs about 2400 cycles
    initial begin
        repeat (30000) @(posedge aclk);
        failures++;
        stop_test();
    end
endmodule
